// file: design/ssfc_pkg.sv
/*
  Shared types and constants of the second-stage fault classifier: register map, reset values,
  request and response carriers and the fault reason codes.
  Assumes a single 100 MHz clock domain and a synchronous, active-high reset.
*/
package ssfc_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one aligned 32-bit word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MASK = 8'h08;
  localparam logic [7:0] OFF_LAST_REASON = 8'h0c;
  localparam logic [7:0] OFF_FAULT_COUNT = 8'h10;

  // Control register fields.
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_COHERENCY_BIT = 2;
  localparam logic [1:0] MODE_SCALABLE = 2'h1;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic COHERENCY_RESET = 1'b0;

  // Status and mask bits.
  localparam int EVT_FAULT = 0;
  localparam int EVT_OVERRUN = 1;
  localparam int EVT_WIDTH = 2;
  localparam logic [EVT_WIDTH-1:0] MASK_RESET = 2'h0;

  // Non-canonical address check: canonical address widths (sign bit is one below).
  localparam int CANON_BITS_4LVL = 48;
  localparam int CANON_BITS_5LVL = 57;

  // ----------------------------------------------------------------------
  // Fault reason codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] RSN_NONE = 8'h00;
  localparam logic [7:0] RSN_NEXT_FETCH = 8'h78;
  localparam logic [7:0] RSN_NO_PERM = 8'h79;
  localparam logic [7:0] RSN_RSVD = 8'h7a;
  localparam logic [7:0] RSN_TOP_FETCH = 8'h7b;
  localparam logic [7:0] RSN_AD_NOSNOOP = 8'h7c;
  localparam logic [7:0] RSN_AD_UPDATE = 8'h7d;
  localparam logic [7:0] RSN_NONCANON = 8'h80;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    REQ_UNTRANSLATED = 4'h1,
    REQ_TRANSLATION = 4'h2,
    REQ_TRANSLATED = 4'h4,
    REQ_PAGE = 4'h8
  } ssfc_kind_e;

  typedef enum logic [2:0] {
    RSP_PASS = 3'h0,
    RSP_UR = 3'h1,
    RSP_CA = 3'h2,
    RSP_NOPERM = 3'h3,
    RSP_NA = 3'h4
  } ssfc_rsp_e;

  typedef struct packed {
    ssfc_kind_e kind;
    logic firstStage;
    logic fiveLevel;
    logic [63:0] inAddr;
    logic topFetchErr;
    logic nextFetchErr;
    logic entryRead;
    logic entryWrite;
    logic andRead;
    logic andWrite;
    logic rsvdNonzero;
    logic walkSnoop;
    logic adEnable;
    logic adFlag;
    logic adUpdateFail;
  } ssfc_req_s;

  typedef struct packed {
    ssfc_rsp_e code;
    logic fault;
    logic [7:0] reason;
  } ssfc_rsp_s;

  localparam ssfc_rsp_s RSP_RESET = '{code: RSP_PASS, fault: 1'b0, reason: RSN_NONE};

endpackage : ssfc_pkg

// file: design/ssfc_canon_check.sv
/*
  Combinational check that a 64-bit input address is canonical for four- or five-level paging.
  Assumes the caller gates the result with first-stage use and scalable mode.
*/
`timescale 1ns/10ps
module ssfc_canon_check
  import ssfc_pkg::*;
(
  input wire logic [63:0] addr,  // Input address of the request.
  input wire logic fiveLevel,    // High for five-level paging.
  output logic nonCanon          // High when the upper bits differ from the sign bit.
);

  logic [63-CANON_BITS_4LVL+1:0] top4;
  logic [63-CANON_BITS_5LVL+1:0] top5;

  assign top4 = addr[63:CANON_BITS_4LVL-1];
  assign top5 = addr[63:CANON_BITS_5LVL-1];

  always_comb
  begin
    if (fiveLevel)
    begin
      nonCanon = !((&top5) || !(|top5));
    end
    else
    begin
      nonCanon = !((&top4) || !(|top4));
    end
  end

endmodule : ssfc_canon_check

// file: design/ssfc_irq_ctrl.sv
/*
  Sticky event status with write-one-to-clear, a mask of the same layout and a level interrupt.
  Assumes event pulses and register write strobes are synchronous to clk.
*/
`timescale 1ns/10ps
module ssfc_irq_ctrl
  import ssfc_pkg::*;
(
  input wire logic clk,                        // System clock.
  input wire logic rst,                        // Synchronous reset, active high.
  input wire logic [EVT_WIDTH-1:0] evt,        // One-cycle event pulses.
  input wire logic clrWr,                      // Status write strobe.
  input wire logic [EVT_WIDTH-1:0] clrData,    // Ones clear status bits.
  input wire logic maskWr,                     // Mask write strobe.
  input wire logic [EVT_WIDTH-1:0] maskData,   // New mask value.
  output logic [EVT_WIDTH-1:0] status,         // Sticky status.
  output logic [EVT_WIDTH-1:0] mask,           // Interrupt enable mask.
  output logic irq                             // Level interrupt, registered.
);

  logic [EVT_WIDTH-1:0] status_ff;
  logic [EVT_WIDTH-1:0] mask_ff;
  logic irq_ff;
  logic [EVT_WIDTH-1:0] nxt_status;

  // A new event in the same cycle as its clear survives, so no event is lost.
  assign nxt_status = (status_ff & ~(clrWr ? clrData : '0)) | evt;

  always_ff @(posedge clk)
  begin
    if (rst)
      status_ff <= '0;
    else
      status_ff <= nxt_status;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      mask_ff <= MASK_RESET;
    else if (maskWr)
      mask_ff <= maskData;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      irq_ff <= 1'b0;
    else
      irq_ff <= |(nxt_status & (maskWr ? maskData : mask_ff));
  end

  assign status = status_ff;
  assign mask = mask_ff;
  assign irq = irq_ff;

endmodule : ssfc_irq_ctrl

// file: design/ssfc_classifier.sv
/*
  Second-stage fault classifier: takes one walk result per request, picks a single fault reason
  and the completion for the requester, and records faults for software over Avalon-MM.
  Assumes the page walker presents each request as one valid cycle with all result bits stable.
*/
// Our own choices: the register addresses and register access over Avalon-MM.
//
// How it works
// - Checks run only in scalable mode 01b.
// - Lower-level entry fetch error gives 78h.
// - No read/write permission gives 79h, no-perm success for translation requests.
// - Reserved bits with permission set give 7Ah.
// - Top entry fetch error gives 7Bh.
// - Non-snooped walk needing A/D update gives 7Ch.
// - Failed A/D update gives 7Dh.
// - Non-canonical first-stage address gives 80h.
`timescale 1ns/10ps
module ssfc_classifier
  import ssfc_pkg::*;
(
  input wire logic clk,               // System clock, 100 MHz.
  input wire logic rst,               // Synchronous reset, active high.
  input wire logic reqValid,          // Walk result valid, one-cycle pulse.
  input wire ssfc_req_s req,          // Walk result and request kind.
  output ssfc_rsp_s rsp,              // Classified completion.
  output logic rspValid,              // Completion valid, one-cycle pulse.
  input wire logic [7:0] address,     // Avalon byte address.
  input wire logic read,              // Avalon read.
  input wire logic write,             // Avalon write.
  input wire logic [31:0] writedata,  // Avalon write data.
  input wire logic [3:0] byteenable,  // Avalon byte enables.
  output logic [31:0] readdata,       // Avalon read data.
  output logic waitrequest,           // Avalon wait request.
  output logic irq                    // Level interrupt.
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Completion for a recorded fault, depending on the request kind.
  function automatic ssfc_rsp_e rspFor(input logic [7:0] reason, input ssfc_kind_e kind);
    ssfc_rsp_e code;
    code = RSP_NA;
    if (kind == REQ_UNTRANSLATED)
      code = RSP_UR;
    else if (kind == REQ_TRANSLATION)
      code = (reason == RSN_NO_PERM || reason == RSN_NONCANON) ? RSP_NOPERM : RSP_CA;
    return code;
  endfunction : rspFor

  // ----------------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------------
  logic [1:0] mode_ff;
  logic coherency_ff;
  logic busWr;
  logic busAck;
  logic waitrequest_ff;

  assign busAck = (read || write) && !waitrequest_ff;
  assign busWr = write && busAck;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_ff <= MODE_RESET;
      coherency_ff <= COHERENCY_RESET;
    end
    else if (busWr && address == OFF_CTRL && byteenable[0])
    begin
      mode_ff <= writedata[CTRL_MODE_LSB +: 2];
      coherency_ff <= writedata[CTRL_COHERENCY_BIT];
    end
  end

  // ----------------------------------------------------------------------
  // Fault conditions
  // ----------------------------------------------------------------------
  logic scalable;
  logic nonCanon;
  logic condCanon;
  logic condTop;
  logic condNext;
  logic condRsvd;
  logic condPerm;
  logic condNoSnoop;
  logic condAdFail;
  logic checked;

  ssfc_canon_check u_canon (
    .addr(req.inAddr),
    .fiveLevel(req.fiveLevel),
    .nonCanon(nonCanon)
  );

  assign scalable = (mode_ff == MODE_SCALABLE);
  assign checked = scalable && (req.kind == REQ_UNTRANSLATED || req.kind == REQ_TRANSLATION);

  assign condCanon = req.firstStage && nonCanon;
  assign condTop = req.topFetchErr;
  assign condNext = req.nextFetchErr;
  assign condRsvd = req.rsvdNonzero && (req.entryRead || req.entryWrite);
  assign condPerm = (!req.entryRead && !req.entryWrite) || (!req.andRead && !req.andWrite);
  assign condNoSnoop = (!coherency_ff || !req.walkSnoop) && req.adEnable && !req.adFlag;
  assign condAdFail = req.adUpdateFail;

  // ----------------------------------------------------------------------
  // Reason selection
  // ----------------------------------------------------------------------
  // Fixed priority in walk order: the address is checked before the walk starts, a fetch error
  // leaves no entry to inspect, and A/D handling comes only after the entry proved usable.
  logic [7:0] reasonSel;

  always_comb
  begin
    reasonSel = RSN_NONE;
    if (condCanon)
      reasonSel = RSN_NONCANON;
    else if (condTop)
      reasonSel = RSN_TOP_FETCH;
    else if (condNext)
      reasonSel = RSN_NEXT_FETCH;
    else if (condRsvd)
      reasonSel = RSN_RSVD;
    else if (condPerm)
      reasonSel = RSN_NO_PERM;
    else if (condNoSnoop)
      reasonSel = RSN_AD_NOSNOOP;
    else if (condAdFail)
      reasonSel = RSN_AD_UPDATE;
  end

  // ----------------------------------------------------------------------
  // Completion
  // ----------------------------------------------------------------------
  ssfc_rsp_s rsp_ff;
  ssfc_rsp_s nxt_rsp;
  logic rspValid_ff;
  logic newFault;

  assign newFault = reqValid && checked && (reasonSel != RSN_NONE);

  always_comb
  begin
    nxt_rsp = RSP_RESET;
    if (req.kind == REQ_TRANSLATED || req.kind == REQ_PAGE)
      nxt_rsp.code = RSP_NA;
    else if (checked && reasonSel != RSN_NONE)
    begin
      nxt_rsp.fault = 1'b1;
      nxt_rsp.reason = reasonSel;
      nxt_rsp.code = rspFor(reasonSel, req.kind);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rsp_ff <= RSP_RESET;
      rspValid_ff <= 1'b0;
    end
    else
    begin
      rspValid_ff <= reqValid;
      if (reqValid)
        rsp_ff <= nxt_rsp;
    end
  end

  // ----------------------------------------------------------------------
  // Fault record
  // ----------------------------------------------------------------------
  logic [7:0] lastReason_ff;
  logic [31:0] faultCount_ff;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      lastReason_ff <= RSN_NONE;
      faultCount_ff <= '0;
    end
    else if (newFault)
    begin
      lastReason_ff <= reasonSel;
      faultCount_ff <= faultCount_ff + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------------
  logic [EVT_WIDTH-1:0] evt;
  logic [EVT_WIDTH-1:0] status;
  logic [EVT_WIDTH-1:0] mask;
  logic irqInt;

  // An overrun marks a fault that arrived while an earlier one was still unacknowledged.
  assign evt[EVT_FAULT] = newFault;
  assign evt[EVT_OVERRUN] = newFault && status[EVT_FAULT];

  ssfc_irq_ctrl u_irq (
    .clk(clk),
    .rst(rst),
    .evt(evt),
    .clrWr(busWr && address == OFF_STATUS && byteenable[0]),
    .clrData(writedata[EVT_WIDTH-1:0]),
    .maskWr(busWr && address == OFF_MASK && byteenable[0]),
    .maskData(writedata[EVT_WIDTH-1:0]),
    .status(status),
    .mask(mask),
    .irq(irqInt)
  );

  // ----------------------------------------------------------------------
  // Avalon-MM slave
  // ----------------------------------------------------------------------
  // Every access takes one wait cycle; this keeps read data registered at the cost of speed.
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;

  always_comb
  begin
    nxt_readdata = '0;
    unique case (address)
      OFF_CTRL: nxt_readdata = {29'h0, coherency_ff, mode_ff};
      OFF_STATUS: nxt_readdata = {30'h0, status};
      OFF_MASK: nxt_readdata = {30'h0, mask};
      OFF_LAST_REASON: nxt_readdata = {24'h0, lastReason_ff};
      OFF_FAULT_COUNT: nxt_readdata = faultCount_ff;
      default: nxt_readdata = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      waitrequest_ff <= 1'b1;
    else
      waitrequest_ff <= !((read || write) && waitrequest_ff);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      readdata_ff <= '0;
    else if (read && waitrequest_ff)
      readdata_ff <= nxt_readdata;
  end

  assign rsp = rsp_ff;
  assign rspValid = rspValid_ff;
  assign readdata = readdata_ff;
  assign waitrequest = waitrequest_ff;
  assign irq = irqInt;

endmodule : ssfc_classifier

// file: verif/ssfc_classifier_properties.sv
/*
  Checker of the classifier's request, completion and bus ports.
  Assumes it is bound to the classifier and tracks the mode from completed bus writes.
*/
`timescale 1ns/10ps
module ssfc_classifier_properties
  import ssfc_pkg::*;
(
  input wire logic clk,               // Clock.
  input wire logic rst,               // Reset.
  input wire logic reqValid,          // Request valid.
  input wire ssfc_req_s req,          // Request.
  input wire ssfc_rsp_s rsp,          // Completion.
  input wire logic rspValid,          // Completion valid.
  input wire logic [7:0] address,     // Bus address.
  input wire logic write,             // Bus write.
  input wire logic [31:0] writedata,  // Bus data.
  input wire logic [3:0] byteenable,  // Byte enables.
  input wire logic waitrequest,       // Bus wait.
  input wire logic irq                // Interrupt.
);
  logic [1:0] modeFf;
  logic cohFf;
  logic sc, cl, un, tr, ad, np, rv;
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      modeFf <= MODE_RESET;
      cohFf <= COHERENCY_RESET;
    end
    else if (write && !waitrequest && address == OFF_CTRL && byteenable[0])
    begin
      modeFf <= writedata[1:0];
      cohFf <= writedata[CTRL_COHERENCY_BIT];
    end
  end
  assign sc = reqValid && modeFf == MODE_SCALABLE && !req.firstStage;
  assign cl = !req.topFetchErr && !req.nextFetchErr;
  assign un = req.kind == REQ_UNTRANSLATED;
  assign tr = req.kind == REQ_TRANSLATION;
  assign ad = (!cohFf || !req.walkSnoop) && req.adEnable && !req.adFlag;
  assign np = (!req.entryRead && !req.entryWrite) || (!req.andRead && !req.andWrite);
  assign rv = req.rsvdNonzero && (req.entryRead || req.entryWrite);
  a_mode_gate: assert property (reqValid && modeFf != MODE_SCALABLE && (un || tr)
    |=> !rsp.fault && rsp.code == RSP_PASS) else $error("fault outside scalable mode");
  a_next_fetch: assert property (sc && !req.topFetchErr && req.nextFetchErr && un
    |=> rsp.reason == RSN_NEXT_FETCH && rsp.code == RSP_UR) else $error("next fetch fault wrong");
  a_no_perm: assert property (sc && cl && !rv && np && tr
    |=> rsp.reason == RSN_NO_PERM && rsp.code == RSP_NOPERM) else $error("permission fault wrong");
  a_rsvd_field: assert property (sc && cl && rv && tr
    |=> rsp.reason == RSN_RSVD && rsp.code == RSP_CA) else $error("reserved fault wrong");
  a_top_fetch: assert property (sc && req.topFetchErr && tr
    |=> rsp.reason == RSN_TOP_FETCH && rsp.code == RSP_CA) else $error("top fetch fault wrong");
  a_ad_nosnoop: assert property (sc && cl && !rv && !np && ad && un
    |=> rsp.reason == RSN_AD_NOSNOOP && rsp.code == RSP_UR) else $error("snoop fault wrong");
  a_ad_update: assert property (sc && cl && !rv && !np && !ad && req.adUpdateFail && tr
    |=> rsp.reason == RSN_AD_UPDATE && rsp.code == RSP_CA) else $error("update fault wrong");
  a_non_canon: assert property (reqValid && modeFf == MODE_SCALABLE && req.firstStage && !req.fiveLevel
    && !(&req.inAddr[63:47] || !(|req.inAddr[63:47])) && tr
    |=> rsp.reason == RSN_NONCANON && rsp.code == RSP_NOPERM) else $error("canonical fault wrong");
  a_translated_na: assert property (reqValid && !(un || tr) && modeFf == MODE_SCALABLE
    |=> rspValid && !rsp.fault && rsp.code == RSP_NA) else $error("translated request faulted");
  cover property (sc && un && req.nextFetchErr);
  cover property (write && !waitrequest);
  cover property (irq);
endmodule : ssfc_classifier_properties

// file: verif/ssfc_req_model.sv
/*
  Requesting device model: presents one walk result for each cycle that go is high.
  Assumes go and goReq change just after a rising edge.
*/
`timescale 1ns/10ps
module ssfc_req_model
  import ssfc_pkg::*;
(
  input wire logic clk,        // Clock.
  input wire logic rst,        // Reset.
  input wire logic go,         // Issue a request next cycle.
  input wire ssfc_req_s goReq, // Request to issue.
  output logic reqValid,       // Request valid.
  output ssfc_req_s req        // Request fields.
);
  logic reqValidFf;
  ssfc_req_s reqFf;
  // Idle fields are inverted each cycle so the design cannot lean on stale values.
  always_ff @(posedge clk)
  begin
    reqValidFf <= go && !rst;
    reqFf <= rst ? '0 : (go ? goReq : ssfc_req_s'(~reqFf));
  end
  assign reqValid = reqValidFf;
  assign req = reqFf;
endmodule : ssfc_req_model

// file: verif/ssfc_classifier_test.sv
/*
  Self-checking bench of the classifier: requests through the device model, registers over Avalon-MM.
  Assumes a 100 MHz clock and the checker bound at the foot of this file.
*/
`timescale 1ns/10ps
module ssfc_classifier_test
  import ssfc_pkg::*;
;
  typedef struct packed {
    logic [2:0] cond;
    logic [7:0] rsn;
    ssfc_rsp_e tcode;
  } ssfc_row_s;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic go = 1'b0;
  ssfc_req_s goReq = '0;
  logic reqValid;
  ssfc_req_s req;
  ssfc_rsp_s rsp;
  logic rspValid;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq;
  logic [31:0] rd;
  ssfc_req_s r;
  ssfc_row_s rows [8];
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int nFault = 0;
  always #5 clk = ~clk;
  ssfc_req_model model (.clk(clk), .rst(rst), .go(go), .goReq(goReq), .reqValid(reqValid), .req(req));
  ssfc_classifier DUT (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req), .rsp(rsp), .rspValid(rspValid),
    .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task final_report;
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report
  // Waitrequest is looked at between edges, so the edge that completes the access is known before it comes.
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    #1;
    while (waitrequest !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask : bus
  function automatic ssfc_req_s mk(input ssfc_kind_e k, input logic [2:0] c);
    ssfc_req_s q;
    q = '0;
    q.kind = k;
    {q.entryRead, q.entryWrite, q.andRead, q.andWrite, q.walkSnoop, q.adFlag} = 6'h3f;
    case (c)
      3'h1: q.nextFetchErr = 1'b1;
      3'h2: {q.entryRead, q.entryWrite} = 2'h0;
      3'h3: q.rsvdNonzero = 1'b1;
      3'h4: q.topFetchErr = 1'b1;
      3'h5: {q.walkSnoop, q.adFlag, q.adEnable} = 3'h1;
      3'h6: q.adUpdateFail = 1'b1;
      3'h7: {q.firstStage, q.inAddr} = {1'b1, 64'h0000_8000_0000_0000};
      default: ;
    endcase
    return q;
  endfunction : mk
  task ex(input ssfc_rsp_e code, input logic [7:0] rsn);
    chk("code", rsp.code, code);
    chk("fault", rsp.fault, rsn != RSN_NONE);
    if (rsn != RSN_NONE)
    begin
      chk("reason", rsp.reason, rsn);
      nFault++;
    end
  endtask : ex
  task req1(input ssfc_req_s q, input ssfc_rsp_e code, input logic [7:0] rsn);
    go <= 1'b1;
    goReq <= q;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk("rspValid", rspValid, 1'b1);
    ex(code, rsn);
    @(posedge clk);
  endtask : req1
  always @(posedge clk)
  begin
    cyc++;
    if (cyc > 5000)
    begin
      errors++;
      final_report;
    end
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    rows = '{'{3'h0, RSN_NONE, RSP_PASS}, '{3'h1, RSN_NEXT_FETCH, RSP_CA}, '{3'h2, RSN_NO_PERM, RSP_NOPERM},
      '{3'h3, RSN_RSVD, RSP_CA}, '{3'h4, RSN_TOP_FETCH, RSP_CA}, '{3'h5, RSN_AD_NOSNOOP, RSP_CA},
      '{3'h6, RSN_AD_UPDATE, RSP_CA}, '{3'h7, RSN_NONCANON, RSP_NOPERM}};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("waitrequest", waitrequest, 1'b1);
    chk("irq", irq, 1'b0);
    chk("rspValid", rspValid, 1'b0);
    @(posedge clk);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, i < 5 ? 8'(4 * i) : 8'h40, 32'h0);
      chk("reset read", rd, 32'h0);
    end
    req1(mk(REQ_UNTRANSLATED, 3'h4), RSP_PASS, RSN_NONE);
    bus(1'b1, OFF_CTRL, 32'h2);
    req1(mk(REQ_TRANSLATION, 3'h2), RSP_PASS, RSN_NONE);
    bus(1'b1, OFF_CTRL, 32'h1);
    foreach (rows[i])
    begin
      req1(mk(REQ_UNTRANSLATED, rows[i].cond), rows[i].cond == 3'h0 ? RSP_PASS : RSP_UR, rows[i].rsn);
      req1(mk(REQ_TRANSLATION, rows[i].cond), rows[i].tcode, rows[i].rsn);
      req1(mk(REQ_TRANSLATED, rows[i].cond), RSP_NA, RSN_NONE);
      req1(mk(REQ_PAGE, rows[i].cond), RSP_NA, RSN_NONE);
    end
    r = mk(REQ_TRANSLATION, 3'h4);
    {r.nextFetchErr, r.rsvdNonzero, r.entryRead} = 3'h6;
    req1(r, RSP_CA, RSN_TOP_FETCH);
    r = mk(REQ_TRANSLATION, 3'h7);
    r.fiveLevel = 1'b1;
    req1(r, RSP_PASS, RSN_NONE);
    r.inAddr = 64'h0100_0000_0000_0000;
    req1(r, RSP_NOPERM, RSN_NONCANON);
    r.fiveLevel = 1'b0;
    r.inAddr = 64'hffff_8000_0000_0000;
    req1(r, RSP_PASS, RSN_NONE);
    bus(1'b1, OFF_CTRL, 32'h5);
    req1(mk(REQ_UNTRANSLATED, 3'h5), RSP_UR, RSN_AD_NOSNOOP);
    r = mk(REQ_UNTRANSLATED, 3'h5);
    r.walkSnoop = 1'b1;
    req1(r, RSP_PASS, RSN_NONE);
    go <= 1'b1;
    goReq <= mk(REQ_UNTRANSLATED, 3'h1);
    @(posedge clk);
    goReq <= mk(REQ_TRANSLATION, 3'h3);
    @(posedge clk);
    go <= 1'b0;
    #1;
    ex(RSP_UR, RSN_NEXT_FETCH);
    @(posedge clk);
    #1;
    ex(RSP_CA, RSN_RSVD);
    @(posedge clk);
    bus(1'b0, OFF_LAST_REASON, 32'h0);
    chk("last reason", rd, {24'h0, RSN_RSVD});
    bus(1'b0, OFF_FAULT_COUNT, 32'h0);
    chk("count", rd, nFault);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, 32'h3);
    #1;
    chk("irq", irq, 1'b0);
    @(posedge clk);
    bus(1'b1, OFF_MASK, 32'h1);
    #1;
    chk("irq", irq, 1'b1);
    @(posedge clk);
    bus(1'b1, OFF_STATUS, 32'h1);
    #1;
    chk("irq", irq, 1'b0);
    @(posedge clk);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("status", rd, 32'h2);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", rd, 32'h0);
    // A reset in mid-run must drop the mode and the status it built up.
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk("status after reset", rd, 32'h0);
    bus(1'b0, OFF_CTRL, 32'h0);
    chk("ctrl after reset", rd, 32'h0);
    req1(mk(REQ_UNTRANSLATED, 3'h1), RSP_PASS, RSN_NONE);
    final_report;
  end
endmodule : ssfc_classifier_test
bind ssfc_classifier ssfc_classifier_properties props (.clk(clk), .rst(rst), .reqValid(reqValid), .req(req),
  .rsp(rsp), .rspValid(rspValid), .address(address), .write(write), .writedata(writedata),
  .byteenable(byteenable), .waitrequest(waitrequest), .irq(irq));
